// *** design/idsk_exec.sv ***
//----------------------------------------------------------------------
// Purpose : Execute stage for inc/dec file, skip variants, OR literal
// Assumes : file_rdata is the addressed register, valid in issue cycle
// Notes   : Results land one clock after issue
//
// Operation
// [RULE_01] Decrement file; d=0 to W, else file
// [RULE_02] Plain decrement updates zero; d=0 writes W
// [RULE_03] Increment file, update zero, route by d
// [RULE_04] Decrement-skip routes by d, status untouched
// [RULE_05] Decrement-skip zero result turns next into nop
// [RULE_06] Increment-skip routes by d, status untouched
// [RULE_07] Increment-skip zero result turns next into nop
// [RULE_08] OR literal into W, update zero
// [RULE_09] Zero flag set only on all-zero result
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module idsk_exec
   import idsk_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire idsk_op_t    instr_op,
   input  wire logic [6:0]  file_addr,
   input  wire logic        dest_sel,
   input  wire logic [7:0]  literal,
   input  wire logic [7:0]  file_rdata,
   output logic             squash_nop,
   output logic             file_we_q,
   output logic [6:0]       file_waddr_q,
   output logic [7:0]       file_wdata_q,
   output logic [7:0]       w_q,
   output logic             zero_q,
   output logic             skip_q
);

   //-------------------------------------------------------------------
   // Issue qualification
   //-------------------------------------------------------------------
   logic  exec_go;
   logic  is_file;
   logic  is_skip;
   logic  upd_zero;
   logic  to_w;
   logic  to_f;

   idsk_alu_if  alu_bus ();

   // A pending skip eats the next valid instruction as a nop
   assign squash_nop = instr_valid && skip_q;
   assign exec_go    = instr_valid && !skip_q;
   assign is_file    = idsk_is_file_op(instr_op);
   assign is_skip    = idsk_is_skip_op(instr_op);

   // Skip variants never touch status
   assign upd_zero = exec_go &&
                     (instr_op == decrement_file_op ||
                      instr_op == increment_file_op ||
                      instr_op == or_literal_working_op);
   assign to_w = exec_go &&
                 ((is_file && dest_sel == IDSK_DEST_W) ||
                  instr_op == or_literal_working_op);
   assign to_f = exec_go && is_file && dest_sel == IDSK_DEST_F;

   assign alu_bus.op        = instr_op;
   assign alu_bus.operand_f = file_rdata;
   assign alu_bus.operand_w = w_q;
   assign alu_bus.literal   = literal;

   idsk_alu u_alu (
      .alu_bus (alu_bus.alu)
   );

   //-------------------------------------------------------------------
   // Working register
   //-------------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         w_q <= IDSK_W_RST;
      end else if (to_w) begin
         w_q <= alu_bus.result;  // RULE_01 RULE_02 RULE_03 RULE_08
      end
   end

   //-------------------------------------------------------------------
   // File register write-back
   //-------------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         file_we_q    <= 1'b0;
         file_waddr_q <= IDSK_ADDR_RST;
         file_wdata_q <= IDSK_W_RST;
      end else begin
         file_we_q <= to_f;  // RULE_01 RULE_03 RULE_04 RULE_06
         if (to_f) begin
            file_waddr_q <= file_addr;
            file_wdata_q <= alu_bus.result;
         end
      end
   end

   //-------------------------------------------------------------------
   // Zero flag
   //-------------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         zero_q <= IDSK_Z_RST;
      end else if (upd_zero) begin
         zero_q <= alu_bus.zero;  // RULE_09 RULE_02 RULE_03 RULE_08
      end
   end

   //-------------------------------------------------------------------
   // Skip pending
   //-------------------------------------------------------------------
   // Held until a valid slot is consumed, so gaps in issue lose nothing
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         skip_q <= 1'b0;
      end else if (exec_go && is_skip) begin
         skip_q <= alu_bus.zero;  // RULE_05 RULE_07
      end else if (instr_valid) begin
         skip_q <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_dec_to_w: assert property ( // RULE_01
      exec_go && instr_op == decrement_file_op && !dest_sel
      |=> w_q == 8'($past(file_rdata) - 8'h01) && !file_we_q)
      else $error("decrement to W wrong");

   a_dec_to_file: assert property ( // RULE_01
      exec_go && instr_op == decrement_file_op && dest_sel
      |=> file_we_q && file_wdata_q == 8'($past(file_rdata) - 8'h01)
          && file_waddr_q == $past(file_addr) && $stable(w_q))
      else $error("decrement to file wrong");

   a_dec_zero_flag: assert property ( // RULE_02
      exec_go && instr_op == decrement_file_op
      |=> zero_q == ($past(file_rdata) == 8'h01))
      else $error("decrement zero flag wrong");

   a_inc_to_file: assert property ( // RULE_03
      exec_go && instr_op == increment_file_op && dest_sel
      |=> file_we_q && file_wdata_q == 8'($past(file_rdata) + 8'h01)
          && file_waddr_q == $past(file_addr) && $stable(w_q))
      else $error("increment to file wrong");

   a_inc_zero_flag: assert property ( // RULE_03
      exec_go && instr_op == increment_file_op
      |=> zero_q == ($past(file_rdata) == 8'hFF))
      else $error("increment zero flag wrong");

   a_inc_to_w: assert property ( // RULE_03
      exec_go && instr_op == increment_file_op && !dest_sel
      |=> w_q == 8'($past(file_rdata) + 8'h01) && !file_we_q)
      else $error("increment to W wrong");

   a_skip_status_kept: assert property ( // RULE_04
      exec_go && is_skip |=> $stable(zero_q))
      else $error("skip op changed status");

   a_dec_skip_route: assert property ( // RULE_04
      exec_go && instr_op == decrement_skip_zero_op && dest_sel
      |=> file_we_q && file_wdata_q == 8'($past(file_rdata) - 8'h01))
      else $error("decrement-skip routing wrong");

   a_dec_skip_nop: assert property ( // RULE_05
      exec_go && instr_op == decrement_skip_zero_op
      |=> skip_q == ($past(file_rdata) == 8'h01))
      else $error("decrement-skip decision wrong");

   a_inc_skip_nop: assert property ( // RULE_07
      exec_go && instr_op == increment_skip_zero_op
      |=> skip_q == ($past(file_rdata) == 8'hFF))
      else $error("increment-skip decision wrong");

   a_inc_skip_route: assert property ( // RULE_06
      exec_go && instr_op == increment_skip_zero_op && !dest_sel
      |=> w_q == 8'($past(file_rdata) + 8'h01) && $stable(zero_q))
      else $error("increment-skip routing wrong");

   a_squash_effect: assert property ( // RULE_05
      squash_nop
      |=> !file_we_q && $stable(w_q) && $stable(zero_q) && !skip_q)
      else $error("squashed slot had effect");

   // Idle gaps must not consume the nop slot
   a_skip_held_idle: assert property ( // RULE_05
      skip_q && !instr_valid |=> skip_q && !file_we_q)
      else $error("pending skip lost in idle gap");

   a_or_literal: assert property ( // RULE_08
      exec_go && instr_op == or_literal_working_op
      |=> w_q == ($past(w_q) | $past(literal)) && !file_we_q
          && zero_q == (($past(w_q) | $past(literal)) == 8'h00))
      else $error("OR literal wrong");

   a_zero_meaning: assert property ( // RULE_09
      upd_zero
      |=> zero_q == (($past(to_w) ? w_q : file_wdata_q) == 8'h00))
      else $error("zero flag meaning wrong");

   c_dec_skip_taken: cover property (
      exec_go && instr_op == decrement_skip_zero_op
      && file_rdata == 8'h01 ##1 squash_nop);

   c_inc_skip_taken: cover property (
      exec_go && instr_op == increment_skip_zero_op
      && file_rdata == 8'hFF ##1 squash_nop);

   c_inc_wrap_zero: cover property (
      exec_go && instr_op == increment_file_op && file_rdata == 8'hFF);

   c_or_nonzero: cover property (
      exec_go && instr_op == or_literal_working_op ##1 !zero_q);

   c_skip_over_gap: cover property (
      skip_q && !instr_valid ##1 squash_nop);

endmodule // idsk_exec
`default_nettype wire

// *** design/idsk_pkg.sv ***
//----------------------------------------------------------------------
// Purpose : Shared constants and types for the inc/dec/skip/OR datapath
// Assumes : 8-bit data, 7-bit file address, one instruction per clock
// Notes   : Reset values other than skip_q and file_we_q, and operand constants, live here
//----------------------------------------------------------------------
package idsk_pkg;

   localparam int          IDSK_DATA_W    = 8;
   localparam int          IDSK_ADDR_W    = 7;
   localparam logic [7:0]  IDSK_ONE       = 8'h01;
   localparam logic [7:0]  IDSK_ALL_ONES  = 8'hFF;
   localparam logic [7:0]  IDSK_W_RST     = 8'h00;
   localparam logic        IDSK_Z_RST     = 1'b0;
   localparam logic        IDSK_DEST_W    = 1'b0;
   localparam logic        IDSK_DEST_F    = 1'b1;
   localparam logic [6:0]  IDSK_ADDR_RST  = 7'h00;

   typedef enum logic [2:0] {
      idle_op,
      decrement_file_op,
      increment_file_op,
      decrement_skip_zero_op,
      increment_skip_zero_op,
      or_literal_working_op
   } idsk_op_t;

   function automatic logic idsk_is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction

   function automatic logic idsk_is_file_op(input idsk_op_t op);
      return op == decrement_file_op || op == increment_file_op ||
             op == decrement_skip_zero_op ||
             op == increment_skip_zero_op;
   endfunction

   function automatic logic idsk_is_skip_op(input idsk_op_t op);
      return op == decrement_skip_zero_op ||
             op == increment_skip_zero_op;
   endfunction

endpackage

// *** design/idsk_alu_if.sv ***
//----------------------------------------------------------------------
// Purpose : Operand and result bundle between core and arithmetic unit
// Assumes : Purely combinational path
// Notes   : None
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
interface idsk_alu_if;
   import idsk_pkg::*;
   idsk_op_t    op;
   logic [7:0]  operand_f;
   logic [7:0]  operand_w;
   logic [7:0]  literal;
   logic [7:0]  result;
   logic        zero;

   modport core (output op, output operand_f, output operand_w,
                 output literal, input result, input zero);
   modport alu  (input op, input operand_f, input operand_w,
                 input literal, output result, output zero);
endinterface
`default_nettype wire

// *** design/idsk_alu.sv ***
//----------------------------------------------------------------------
// Purpose : Result and zero detect for inc, dec and OR-literal
// Assumes : Operands stable within the cycle
// Notes   : Wraps modulo 256 on both inc and dec
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module idsk_alu
   import idsk_pkg::*;
(
   idsk_alu_if.alu  alu_bus
);

   always_comb begin
      case (alu_bus.op)
         decrement_file_op,
         decrement_skip_zero_op: begin
            alu_bus.result = alu_bus.operand_f - IDSK_ONE;
         end
         increment_file_op,
         increment_skip_zero_op: begin
            alu_bus.result = alu_bus.operand_f + IDSK_ONE;
         end
         or_literal_working_op: begin
            alu_bus.result = alu_bus.operand_w | alu_bus.literal;
         end
         default: begin
            alu_bus.result = alu_bus.operand_w;
         end
      endcase
      alu_bus.zero = idsk_is_zero(alu_bus.result);
   end

endmodule // idsk_alu
`default_nettype wire

// *** dv/idsk_tb.sv ***
//----------------------------------------------------------------------
// Purpose : Self-checking bench for the inc/dec/skip/OR execute stage
// Assumes : Bench stands in for the register file, read data driven
// Notes   : Inputs change on the falling edge, outputs checked there
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import idsk_pkg::*;

   logic        mclk;
   logic        nrst;
   logic        instr_valid;
   idsk_op_t    instr_op;
   logic [6:0]  file_addr;
   logic        dest_sel;
   logic [7:0]  literal;
   logic [7:0]  file_rdata;
   logic        squash_nop;
   logic        file_we_q;
   logic [6:0]  file_waddr_q;
   logic [7:0]  file_wdata_q;
   logic [7:0]  w_q;
   logic        zero_q;
   logic        skip_q;
   int          failures;
   int          checks;
   int          cycles;
   logic        e_we, e_z, e_skip;
   logic [6:0]  e_addr;
   logic [7:0]  e_data, e_w, rd, k;

   idsk_exec dut (.mclk(mclk), .nrst(nrst), .instr_valid(instr_valid),
      .instr_op(instr_op), .file_addr(file_addr), .dest_sel(dest_sel),
      .literal(literal), .file_rdata(file_rdata), .squash_nop(squash_nop),
      .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
      .file_wdata_q(file_wdata_q), .w_q(w_q), .zero_q(zero_q),
      .skip_q(skip_q));

   //-------------------------------------------------------------------
   // Clock, timeout and closing report
   //-------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // About 1500 slots are issued; a hang stops well past that
   always @(posedge mclk) begin
      cycles++;
      if (cycles >= 5000) begin
         failures++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   //-------------------------------------------------------------------
   // Expectation helpers
   //-------------------------------------------------------------------
   function automatic logic [7:0] calc(idsk_op_t op, logic [7:0] f,
                                       logic [7:0] w, logic [7:0] lit);
      if (op == decrement_file_op || op == decrement_skip_zero_op)
         return f - 8'h01;
      if (op == or_literal_working_op)
         return w | lit;
      return f + 8'h01;
   endfunction

   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_state();
      chk("file_we_q", {7'h00, e_we}, {7'h00, file_we_q});
      chk("file_waddr_q", {1'b0, e_addr}, {1'b0, file_waddr_q});
      chk("file_wdata_q", e_data, file_wdata_q);
      chk("w_q", e_w, w_q);
      chk("zero_q", {7'h00, e_z}, {7'h00, zero_q});
      chk("skip_q", {7'h00, e_skip}, {7'h00, skip_q});
   endtask

   // One issue slot: check last result, drive, then predict this one
   task automatic step(logic v, idsk_op_t op, logic [6:0] a, logic d,
                       logic [7:0] lit, logic [7:0] f);
      logic [7:0] r;
      @(negedge mclk);
      check_state();
      instr_valid = v;
      instr_op    = op;
      file_addr   = a;
      dest_sel    = d;
      literal     = lit;
      file_rdata  = f;
      #1;
      chk("squash_nop", {7'h00, v & e_skip}, {7'h00, squash_nop});
      r    = calc(op, f, e_w, lit);
      e_we = 1'b0;
      if (v && e_skip) begin
         e_skip = 1'b0;
      end else if (v && op != idle_op) begin
         if (op == or_literal_working_op || !d) begin
            e_w = r;
         end else begin
            e_we   = 1'b1;
            e_addr = a;
            e_data = r;
         end
         if (op == decrement_file_op || op == increment_file_op ||
             op == or_literal_working_op)
            e_z = (r == 8'h00);
         e_skip = (op == decrement_skip_zero_op ||
                   op == increment_skip_zero_op) && r == 8'h00;
      end
   endtask

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial begin
      failures = 0;
      checks = 0;
      cycles = 0;
      nrst = 1'b0;
      instr_valid = 1'b0;
      instr_op = idle_op;
      file_addr = 7'h00;
      dest_sel = 1'b0;
      literal = 8'h00;
      file_rdata = 8'h00;
      {e_we, e_z, e_skip, e_addr, e_data, e_w} = '0;
      void'($urandom(32'hd271_84a8));
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      // Directed corners: wraps, skips around idle gaps, zero OR
      step(1, decrement_file_op, 7'h05, 0, 8'h00, 8'h05);
      step(1, increment_file_op, 7'h7F, 1, 8'h00, 8'hFF);
      step(1, decrement_skip_zero_op, 7'h00, 1, 8'h00, 8'h01);
      step(1, or_literal_working_op, 7'h00, 0, 8'h5A, 8'h00);
      step(1, increment_skip_zero_op, 7'h11, 0, 8'h00, 8'hFF);
      step(0, increment_file_op, 7'h12, 1, 8'h00, 8'h33);
      step(1, increment_file_op, 7'h13, 1, 8'h00, 8'h44);
      step(1, decrement_skip_zero_op, 7'h14, 0, 8'h00, 8'h00);
      step(1, increment_skip_zero_op, 7'h15, 1, 8'h00, 8'h01);
      step(1, decrement_file_op, 7'h16, 0, 8'h00, 8'h01);
      step(1, or_literal_working_op, 7'h00, 0, 8'h00, 8'h00);
      step(1, or_literal_working_op, 7'h00, 0, 8'h80, 8'h00);
      // Mid-run reset with a skip pending must drop it
      step(1, decrement_skip_zero_op, 7'h21, 0, 8'h00, 8'h01);
      @(negedge mclk);
      check_state();
      nrst = 1'b0;
      instr_valid = 1'b0;
      {e_we, e_z, e_skip, e_addr, e_data, e_w} = '0;
      repeat (2) @(negedge mclk);
      check_state();
      nrst = 1'b1;
      step(1, increment_file_op, 7'h22, 0, 8'h00, 8'h7F);
      // Random traffic, biased towards values that give zero results
      for (int i = 0; i < 1500; i++) begin
         case ($urandom_range(0, 3))
            0: rd = 8'h00;
            1: rd = 8'h01;
            2: rd = 8'hFF;
            default: rd = 8'($urandom);
         endcase
         k = ($urandom_range(0, 3) == 0) ? 8'h00 : 8'($urandom);
         step($urandom_range(0, 7) != 0, idsk_op_t'($urandom_range(0, 5)),
              7'($urandom), 1'($urandom), k, rd);
      end
      @(negedge mclk);
      check_state();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
